/* File: pkg/catsio_pkg.sv */
/*
  Constants for the camera auxiliary trigger and sync I/O block.
  Assumes a single 20 MHz system clock and synchronous active-high reset.
*/
`default_nettype none
package catsio_pkg;
    // System clock period in picoseconds (20 MHz)
    localparam int unsigned CLK_PERIOD_PS = 50000;
    // Trigger echo width in nanoseconds, as printed 6 us
    localparam int unsigned ECHO_WIDTH_NS = 6000;
    // Echo width in cycles, least time so rounded up
    localparam int unsigned ECHO_CYCLES =
        (ECHO_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Counter width for the echo timer
    localparam int unsigned ECHO_CNT_W = 8;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;
    // Idle level of every trigger input (triggers are active on fall)
    localparam logic TRIG_IDLE = 1'b1;
endpackage
`default_nettype wire

/* File: rtl/catsio_fall_detect.sv */
/*
  Two-flop synchroniser with falling-edge detector for one trigger input.
  Assumes the input may be asynchronous; reset level is the idle level.
*/
`timescale 1ns/100ps
`default_nettype none
module catsio_fall_detect (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic trig_in,
    output logic fall_out
);
    // Synchroniser chain, first stage read only by the second
    logic meta_q;
    logic sync_q;
    // Previous synchronised level for edge detection
    logic prev_q;

    // Synchronise and delay
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            meta_q <= catsio_pkg::TRIG_IDLE;
            sync_q <= catsio_pkg::TRIG_IDLE;
            prev_q <= catsio_pkg::TRIG_IDLE;
        end else begin
            meta_q <= trig_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // High-to-low seen on the synchronised level
    assign fall_out = prev_q & ~sync_q;
endmodule // catsio_fall_detect
`default_nettype wire

/* File: rtl/catsio_top.sv */
/*
  Auxiliary trigger and sync I/O: merges three falling-edge trigger
  sources into one exposure request, emits a fixed-width echo pulse and
  drives strobe, line-valid and frame-valid outputs from sensor timing.
  Assumes sensor timing inputs are synchronous to clk_sys_in.
*/
`timescale 1ns/100ps
`default_nettype none
module catsio_top #(
    parameter int unsigned ECHO_CYCLES = catsio_pkg::ECHO_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic trig_se_in,          // Single-ended trigger
    input wire logic trig_diff_p_in,      // Differential trigger, positive
    input wire logic trig_diff_n_in,      // Differential trigger, negative
    input wire logic host_trig_in,        // Host control line CC1
    input wire logic trig_se_en_in,       // Source enables
    input wire logic trig_diff_en_in,
    input wire logic host_trig_en_in,
    input wire logic overlap_mode_in,     // Continuous overlapped exposure
    input wire logic sensor_exposing_in,  // Sensor integrating
    input wire logic line_active_in,      // Valid portion of a line
    input wire logic frame_active_in,     // Active readout lines of frame
    output logic exposure_start_out,      // One-cycle start request
    output logic trigger_echo_out,
    output logic strobe_out,
    output logic line_valid_out,
    output logic frame_valid_out
);
    // Refuse echo widths the counter cannot hold
    initial begin
        if (ECHO_CYCLES < 1 || ECHO_CYCLES >= (1 << catsio_pkg::ECHO_CNT_W))
            $error("ECHO_CYCLES out of range");
    end

    // Timing overview, counted in system clock edges from the edge that
    // first samples a trigger pin low:
    //   edge 1  first synchroniser stage goes low
    //   edge 2  second stage low, the edge detector raises start_d
    //   edge 3  start request and echo pulse both go high
    //   edge 4  start request drops, echo keeps running on its counter
    // The echo counter is reloaded by every accepted edge, so a trigger
    // that arrives during a pulse stretches it to a full width again.
    // Two falls on the same pin need a rise in between, so one source can
    // never ask twice in adjacent cycles; separate sources can, and then
    // the requests simply merge.
    // Sensor timing levels are only registered once. They are expected to
    // come from logic on the same clock, so no synchroniser is spent there.

    // Differential receiver: positive above negative reads high
    // Both legs equal counts as low, which the pair never shows when driven
    logic diff_level;
    assign diff_level = trig_diff_p_in & ~trig_diff_n_in;

    // Per-source falling edges
    // Single-ended pin
    logic se_fall;
    // Differential pair
    logic diff_fall;
    // Host control line
    logic host_fall;

    catsio_fall_detect u_se (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .trig_in(trig_se_in),
        .fall_out(se_fall)
    );
    catsio_fall_detect u_diff (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .trig_in(diff_level),
        .fall_out(diff_fall)
    );
    catsio_fall_detect u_host (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .trig_in(host_trig_in),
        .fall_out(host_fall)
    );

    // Merged request from enabled sources
    logic start_d;
    assign start_d = (se_fall & trig_se_en_in) | (diff_fall & trig_diff_en_in)
                   | (host_fall & host_trig_en_in);

    // Registered start request
    logic start_q;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in)
            start_q <= 1'b0;
        else
            start_q <= start_d;
    end
    assign exposure_start_out = start_q;

    // Echo timer; a new edge during a pulse restarts the full width
    logic [catsio_pkg::ECHO_CNT_W-1:0] echo_cnt_q;
    logic echo_q;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            echo_cnt_q <= '0;
            echo_q <= 1'b0;
        end else if (start_d) begin
            echo_cnt_q <= catsio_pkg::ECHO_CNT_W'(ECHO_CYCLES - 1);
            echo_q <= 1'b1;
        end else if (echo_cnt_q != '0) begin
            echo_cnt_q <= echo_cnt_q - 1'b1;
        end else begin
            echo_q <= 1'b0;
        end
    end
    assign trigger_echo_out = echo_q;

    // Sync outputs registered from sensor timing
    logic strobe_q, line_valid_out_q, fval_q;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            strobe_q <= 1'b0;
            line_valid_out_q <= 1'b0;
            fval_q <= 1'b0;
        end else begin
            // Strobe only meaningful in overlapped mode
            strobe_q <= overlap_mode_in & sensor_exposing_in;
            // Gaps between lines and frames force low
            line_valid_out_q <= line_active_in & frame_active_in;
            fval_q <= frame_active_in;
        end
    end
    assign strobe_out = strobe_q;
    assign line_valid_out = line_valid_out_q;
    assign frame_valid_out = fval_q;

    // Assertions run off the system clock and are muted during reset.
    // Echo width is checked step by step against its counter instead of a
    // long repetition, so a large width parameter costs the tools nothing.
    // Follow checks skip attempts that start in the reset cycle, since the
    // registers are still forced low one edge later.

    // A running counter keeps the echo up
    echo_width_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        echo_q && echo_cnt_q != '0 |=> echo_q)
        else $error("echo width");
    // A spent counter with no new edge ends the echo
    echo_end_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        echo_q && echo_cnt_q == '0 && !start_d |=> !echo_q)
        else $error("echo too long");
    // Every launch loads the full width
    echo_load_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        start_d |=> echo_cnt_q == catsio_pkg::ECHO_CNT_W'(ECHO_CYCLES - 1))
        else $error("echo width not loaded");
    // Counter steps down by one each cycle
    echo_step_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        echo_cnt_q != '0 && !start_d |=> echo_cnt_q == $past(echo_cnt_q) - 1'b1)
        else $error("echo count skipped");
    // Idle echo leaves the counter clean
    echo_idle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !echo_q |-> echo_cnt_q == '0)
        else $error("echo counter stale");
    // Echo and start rise together
    echo_launch_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        start_d |=> echo_q && start_q)
        else $error("echo not launched");
    // Strobe only after overlapped exposing
    strobe_mode_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        strobe_q |-> $past(overlap_mode_in) && $past(sensor_exposing_in))
        else $error("strobe outside exposure");
    // Strobe present for every overlapped exposing cycle
    strobe_follow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !sys_rst_in && overlap_mode_in && sensor_exposing_in |=> strobe_q)
        else $error("strobe missing");
    // Line valid never outside a frame
    line_valid_out_gap_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        line_valid_out_q |-> fval_q)
        else $error("line valid in frame gap");
    // Line valid through the valid line part
    line_valid_out_follow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !sys_rst_in && line_active_in && frame_active_in |=> line_valid_out_q)
        else $error("line valid missing");
    // Line valid low in the gap between lines
    line_valid_out_low_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !line_active_in |=> !line_valid_out_q)
        else $error("line valid in line gap");
    // Frame valid tracks the active lines
    fval_follow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> fval_q == $past(frame_active_in))
        else $error("frame valid wrong");
    // Each enabled source reaches the request
    se_start_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        se_fall && trig_se_en_in |=> start_q)
        else $error("se trigger lost");
    diff_start_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        diff_fall && trig_diff_en_in |=> start_q)
        else $error("diff trigger lost");
    host_start_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        host_fall && host_trig_en_in |=> start_q)
        else $error("host trigger lost");
    no_spur_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        start_q |-> $past(start_d))
        else $error("spurious start");
endmodule // catsio_top
`default_nettype wire

/* File: test/catsio_trig_src.sv */
/*
  Model of the external trigger equipment on the three trigger inputs.
  Assumes fire_in and sel_in change just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module catsio_trig_src (
    input wire logic clk_sys_in,
    input wire logic fire_in,
    input wire logic [1:0] sel_in,
    output logic se_out,
    output logic diff_p_out,
    output logic diff_n_out,
    output logic host_out
);
    // All lines idle high, pair idle as p high, n low
    initial {se_out, diff_p_out, diff_n_out, host_out} = 4'hd;
    // Held fire pulls the chosen line low, release gives the rising edge
    always @(posedge clk_sys_in) begin
        se_out <= !(fire_in && sel_in == 2'h0);
        diff_p_out <= !(fire_in && sel_in == 2'h1);
        diff_n_out <= fire_in && sel_in == 2'h1;
        host_out <= !(fire_in && sel_in == 2'h2);
    end
endmodule // catsio_trig_src
`default_nettype wire

/* File: test/catsio_top_tb_top.sv */
/*
  Self-checking bench for the trigger and sync block.
  Assumes the design answers a trigger two edges after sampling it.
*/
`timescale 1ns/100ps
`default_nettype none
module catsio_top_tb_top;
    localparam int unsigned ECH = 4; // Short echo keeps the run brief
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic fire = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [2:0] en = 3'h7; // Host, differential, single-ended
    logic [3:0] tim = 4'h0; // Overlap, exposing, line, frame
    wire logic se, dp, dn, host, start, echo, strobe, lv, fv;
    int fails = 0;
    int compares = 0;
    // Clock at 20 MHz
    initial forever #25 clk_sys_in = ~clk_sys_in;
    catsio_trig_src u_src (.clk_sys_in(clk_sys_in), .fire_in(fire), .sel_in(sel),
        .se_out(se), .diff_p_out(dp), .diff_n_out(dn), .host_out(host));
    catsio_top #(.ECHO_CYCLES(ECH)) u_dut (.clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in), .trig_se_in(se), .trig_diff_p_in(dp),
        .trig_diff_n_in(dn), .host_trig_in(host), .trig_se_en_in(en[0]),
        .trig_diff_en_in(en[1]), .host_trig_en_in(en[2]),
        .overlap_mode_in(tim[3]), .sensor_exposing_in(tim[2]),
        .line_active_in(tim[1]), .frame_active_in(tim[0]),
        .exposure_start_out(start), .trigger_echo_out(echo),
        .strobe_out(strobe), .line_valid_out(lv), .frame_valid_out(fv));
    // Compare one bit, four-state exact
    task check(input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t mismatch seen %b expected %b", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task finish_test;
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One fall on source s; a disabled source must give nothing
    task fire_src(input logic [1:0] s, input logic on);
        @(posedge clk_sys_in);
        sel <= s;
        en <= on ? 3'h7 : ~(3'h1 << s);
        fire <= 1'b1;
        // One cycle low at the pin; model lags one edge, answer four edges on
        @(posedge clk_sys_in);
        fire <= 1'b0;
        repeat (3) begin
            @(negedge clk_sys_in);
            check(start, 1'b0);
        end
        @(negedge clk_sys_in);
        check(start, on);
        for (int i = 0; i < ECH; i++) begin
            check(echo, on);
            if (i == 1) check(start, 1'b0);
            @(negedge clk_sys_in);
        end
        check(echo, 1'b0);
        repeat (4) @(negedge clk_sys_in);
        check(start, 1'b0);
    endtask
    // Every combination of the timing levels, one cycle late at the outputs
    task timing_all;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_in);
            tim <= i[3:0];
            @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            check(strobe, tim[3] & tim[2]);
            check(lv, tim[1] & tim[0]);
            check(fv, tim[0]);
        end
    endtask
    // Reset in mid-run with all timing levels high, then release
    task reset_mid;
        @(posedge clk_sys_in);
        tim <= 4'hf;
        sys_rst_in <= 1'b1;
        repeat (2) @(negedge clk_sys_in);
        check(strobe, 1'b0);
        check(lv, 1'b0);
        check(fv, 1'b0);
        check(echo, 1'b0);
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_sys_in);
        check(fv, 1'b0);
        check(start, 1'b0);
        @(negedge clk_sys_in);
        check(strobe, 1'b1);
        check(lv, 1'b1);
        check(fv, 1'b1);
        @(posedge clk_sys_in);
        tim <= 4'h0;
    endtask
    // Reset, then each source enabled and disabled, then timing outputs
    initial begin
        repeat (12) @(negedge clk_sys_in);
        check(start, 1'b0);
        check(echo, 1'b0);
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            fire_src(s[1:0], 1'b1);
            fire_src(s[1:0], 1'b0);
        end
        timing_all();
        reset_mid();
        fire_src(2'h0, 1'b1);
        finish_test();
    end
endmodule // catsio_top_tb_top
`default_nettype wire
